/* File: design/rsc_pkg.sv */
package rsc_pkg;

  // ----------------------------------------------------------------
  // register placement and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RSC_CAUSE_ADDR    = 8'hef;
  localparam int         RSC_BIT_CMP       = 5;
  localparam int         RSC_BIT_SW        = 4;
  localparam int         RSC_BIT_MCD       = 2;
  localparam int         RSC_BIT_VDM       = 1;
  localparam logic [7:0] RSC_CAUSE_POR_VAL = 8'h02;
  localparam logic [7:0] RSC_READ_MASK     = 8'h7f;
  localparam logic [7:0] RSC_OTHER_THAN_CMP = 8'hdf;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         RSC_CLK_PERIOD_NS = 100;
  localparam int         RSC_RST_HOLD_NS   = 1000;
  localparam int         RSC_RST_HOLD_CYC  =
    (RSC_RST_HOLD_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam logic [3:0] RSC_HOLD_LOAD     = 4'(RSC_RST_HOLD_CYC - 1);
  localparam logic [3:0] RSC_WDT_PRESCALE  = 4'd12;
  localparam int         RSC_WDT_LIMIT_DEF = 256;

  // ----------------------------------------------------------------
  // flash address limit
  // ----------------------------------------------------------------
  localparam logic [15:0] RSC_USER_CODE_TOP = 16'hfbff;
  localparam logic [1:0]  RSC_TOP_BANK      = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSC_ACC_DATA_WRITE,
    RSC_ACC_ERASE,
    RSC_ACC_CODE_READ,
    RSC_ACC_FETCH
  } rsc_acc_kind_t;

  typedef struct packed {
    logic          valid;
    rsc_acc_kind_t kind;
    logic [1:0]    bank;
    logic [15:0]   addr;
    logic          secure_block;
  } rsc_flash_req_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rsc_sfr_req_t;

  // layout matches the register bit for bit
  typedef struct packed {
    logic unused;
    logic flash;
    logic cmp;
    logic sw;
    logic wdt;
    logic lost_clock_detector;
    logic por;
    logic pin;
  } rsc_cause_t;

  typedef enum logic {
    RSC_RUN,
    RSC_HOLD
  } rsc_state_t;

endpackage

/* File: design/rsc_watchdog.sv */
`timescale 1ns/10ps
module rsc_watchdog
  import rsc_pkg::*;
#(
  parameter int LIMIT = RSC_WDT_LIMIT_DEF
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic sys_reset,
  input  wire logic kick,
  input  wire logic off,
  output logic      running,
  output logic      overflow
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic [3:0]  pre;
    logic [15:0] cnt;
    logic        ovf;
  } rsc_wdt_state_t;

  rsc_wdt_state_t r_reg;
  rsc_wdt_state_t r_next;

  if (LIMIT < 2 || LIMIT > 65535) begin : g_chk
    $error("watchdog limit out of range");
  end

  // restart enabled on every system reset, ticking once per 12 clocks
  always_comb begin
    r_next     = r_reg;
    r_next.ovf = 1'b0;
    if (sys_reset) begin
      r_next.en  = 1'b1;
      r_next.pre = 4'h0;
      r_next.cnt = 16'h0000;
    end else if (kick) begin
      r_next.pre = 4'h0;
      r_next.cnt = 16'h0000;
    end else if (off) begin
      r_next.en = 1'b0;
    end else if (r_reg.en) begin
      if (r_reg.pre == RSC_WDT_PRESCALE - 4'd1) begin
        r_next.pre = 4'h0;
        if (r_reg.cnt == 16'(LIMIT - 1)) begin
          r_next.cnt = 16'h0000;
          r_next.ovf = 1'b1;
        end else begin
          r_next.cnt = r_reg.cnt + 16'h0001;
        end
      end else begin
        r_next.pre = r_reg.pre + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{en: 1'b1, pre: 4'h0, cnt: 16'h0000, ovf: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign running  = r_reg.en;
  assign overflow = r_reg.ovf;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_wdt_up_enabled;
    @(posedge mclk) disable iff (!arst_n)
    sys_reset |=> running;
  endproperty
  a_wdt_up_enabled: assert property (p_wdt_up_enabled)
    else $error("watchdog not enabled after reset");

  property p_wdt_prescale;
    @(posedge mclk) disable iff (!arst_n)
    (running && !sys_reset && !kick && !off) |=>
      (r_reg.pre == (($past(r_reg.pre) == RSC_WDT_PRESCALE - 4'd1) ? 4'h0 :
                     $past(r_reg.pre) + 4'h1));
  endproperty
  a_wdt_prescale: assert property (p_wdt_prescale)
    else $error("watchdog prescale is not twelve");

endmodule

/* File: design/rsc_flash_guard.sv */
`timescale 1ns/10ps
module rsc_flash_guard
  import rsc_pkg::*;
#(
  parameter bit REDUCED_MEM = 1'b0
) (
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  wire logic           sys_reset,
  input  wire rsc_flash_req_t req,
  input  wire logic           store_write_en,
  input  wire logic           vdm_enabled,
  input  wire logic           vdm_high,
  input  wire logic           vdm_selected,
  output logic                err
);

  typedef struct packed {
    logic err;
  } rsc_fg_state_t;

  rsc_fg_state_t r_reg;
  rsc_fg_state_t r_next;

  logic beyond;
  logic write_like;
  logic flash_op;
  logic bad;

  // the whole top bank is off limits on the small variant
  always_comb begin
    beyond     = (req.bank == RSC_TOP_BANK) &&
                 (REDUCED_MEM || req.addr > RSC_USER_CODE_TOP);
    write_like = (req.kind == RSC_ACC_DATA_WRITE) || (req.kind == RSC_ACC_ERASE);
    flash_op   = (write_like && store_write_en) || (req.kind == RSC_ACC_CODE_READ);
    bad        = req.valid && (
                 (write_like && store_write_en && beyond) ||
                 (req.kind == RSC_ACC_CODE_READ && beyond) ||
                 (req.kind == RSC_ACC_FETCH && beyond) ||
                 (flash_op && req.secure_block) ||
                 (flash_op && !(vdm_enabled && vdm_high && vdm_selected)));
    r_next     = r_reg;
    r_next.err = bad && !sys_reset;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '{err: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign err = r_reg.err;

  property p_fetch_limit;
    @(posedge mclk) disable iff (!arst_n)
    (req.valid && req.kind == RSC_ACC_FETCH && req.bank == RSC_TOP_BANK &&
     req.addr > RSC_USER_CODE_TOP && !sys_reset) |=> err;
  endproperty
  a_fetch_limit: assert property (p_fetch_limit)
    else $error("fetch beyond code limit not flagged");

endmodule

/* File: design/rsc_reset_source_control.sv */
// Contract
// - bit 5 written 1 enables comparator reset; disabled comparator never resets
// - enabled comparator resets when positive input is below negative input
// - bit 5 reads 1 only after a comparator-caused reset
// - internal reset sources never drive the external reset pin; the supply-monitor reset drives it here
// - watchdog comes up enabled, clocked at system clock over twelve
// - watchdog overflow resets the device and sets bit 3
// - enabled data-space write or erase beyond user limit causes flash reset
// - code-space read beyond user limit causes flash reset
// - fetch or branch beyond user limit causes flash reset
// - flash access forbidden by security settings causes flash reset
// - flash access without high-threshold selected supply monitor causes flash reset
// - bit 6 reads 1 after a flash fault reset
// - bit 4 written 1 forces reset; reads 1 afterwards
// - bit 2 enables lost-clock detector; reads its reset flag
// - bit 1 written 1 selects supply monitor; firmware enables monitor first
// - bit 1 reads 1 after power-on or supply reset
// - bit 0 flags pin reset; bit 7 reads 0, ignores writes
`timescale 1ns/10ps
module rsc_reset_source_control
  import rsc_pkg::*;
#(
  parameter int WDT_LIMIT   = RSC_WDT_LIMIT_DEF,
  parameter bit REDUCED_MEM = 1'b0
) (
  input  wire logic           mclk,
  input  wire logic           arst_n,
  input  wire rsc_sfr_req_t   sfr,
  output logic [7:0]          sfr_rdata,
  input  wire logic           cmp_below,
  input  wire logic           mcd_timeout,
  input  wire logic           vdm_enabled,
  input  wire logic           vdm_high,
  input  wire logic           vdm_below,
  input  wire logic           ext_rst_n,
  input  wire rsc_flash_req_t flash_req,
  input  wire logic           store_write_en,
  input  wire logic           wdt_kick,
  input  wire logic           wdt_off,
  output logic                sys_reset,
  output logic                rst_pin_oe,
  output logic                mcd_enable,
  output logic                vdm_select,
  output logic                wdt_running
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rsc_state_t st;
    logic [3:0] hold;
    rsc_cause_t flags;
    logic       cmp_en;
    logic       mcd_en;
    logic       vdm_sel;
    logic [7:0] rdata;
    logic       sys_rst;
    logic       pin_oe;
  } rsc_top_state_t;

  // power-up: sit in reset with the supply flag set and the pin pulled
  localparam rsc_top_state_t RSC_TOP_RST = '{
    st:      RSC_HOLD,
    hold:    RSC_HOLD_LOAD,
    flags:   rsc_cause_t'(RSC_CAUSE_POR_VAL),
    cmp_en:  1'b0,
    mcd_en:  1'b1,
    vdm_sel: 1'b1,
    rdata:   8'h00,
    sys_rst: 1'b1,
    pin_oe:  1'b1
  };

  rsc_top_state_t r_reg;
  rsc_top_state_t r_next;

  rsc_cause_t cause;
  logic       wr_hit;
  logic       rd_hit;
  logic       supply_low;
  logic       wdt_ovf;
  logic       flash_err;
  logic [6:0] flags_lo;

  if (RSC_RST_HOLD_CYC < 2 || RSC_RST_HOLD_CYC > 16) begin : g_chk
    $error("reset hold count does not fit its counter");
  end

  // ----------------------------------------------------------------
  // request sources
  // ----------------------------------------------------------------
  rsc_watchdog #(
    .LIMIT (WDT_LIMIT)
  ) u_wdt (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .sys_reset (r_reg.sys_rst),
    .kick      (wdt_kick),
    .off       (wdt_off),
    .running   (wdt_running),
    .overflow  (wdt_ovf)
  );

  rsc_flash_guard #(
    .REDUCED_MEM (REDUCED_MEM)
  ) u_fg (
    .mclk           (mclk),
    .arst_n         (arst_n),
    .sys_reset      (r_reg.sys_rst),
    .req            (flash_req),
    .store_write_en (store_write_en),
    .vdm_enabled    (vdm_enabled),
    .vdm_high       (vdm_high),
    .vdm_selected   (r_reg.vdm_sel),
    .err            (flash_err)
  );

  // ----------------------------------------------------------------
  // cause vector, one bit per source, already gated by its enable
  // ----------------------------------------------------------------
  always_comb begin
    wr_hit       = sfr.wr && (sfr.addr == RSC_CAUSE_ADDR) && (r_reg.st == RSC_RUN);
    rd_hit       = sfr.rd && (sfr.addr == RSC_CAUSE_ADDR);
    supply_low   = r_reg.vdm_sel && vdm_enabled && vdm_below;
    cause        = '0;
    cause.pin    = !ext_rst_n;
    cause.por    = supply_low;
    cause.lost_clock_detector    = r_reg.mcd_en && mcd_timeout;
    cause.wdt    = wdt_ovf;
    cause.sw     = wr_hit && sfr.wdata[RSC_BIT_SW];
    cause.cmp    = r_reg.cmp_en && cmp_below;
    cause.flash  = flash_err;
  end

  // ----------------------------------------------------------------
  // sequencer and register
  // ----------------------------------------------------------------
  // writes are taken whole, so a read-back flag written back lands as
  // an enable or a forced reset; firmware must never merge into it
  always_comb begin
    r_next       = r_reg;
    // unmapped reads answer zero; bit 7 is never stored
    r_next.rdata = rd_hit ? (RSC_READ_MASK & 8'(r_reg.flags)) : 8'h00;
    case (r_reg.st)
      RSC_RUN: begin
        if (|cause) begin
          // every source that fires in this cycle is recorded together
          r_next.st      = RSC_HOLD;
          r_next.hold    = RSC_HOLD_LOAD;
          r_next.flags   = cause;
          r_next.sys_rst = 1'b1;
          r_next.pin_oe  = cause.por;
          r_next.cmp_en  = 1'b0;
          // a forcing write is still a plain write, so its lost-clock and supply-monitor enable bits land too; comparator enable clears
          if (wr_hit) begin
            r_next.mcd_en  = sfr.wdata[RSC_BIT_MCD];
            r_next.vdm_sel = sfr.wdata[RSC_BIT_VDM];
          end
        end else if (wr_hit) begin
          r_next.cmp_en  = sfr.wdata[RSC_BIT_CMP];
          r_next.mcd_en  = sfr.wdata[RSC_BIT_MCD];
          r_next.vdm_sel = sfr.wdata[RSC_BIT_VDM];
        end
      end
      RSC_HOLD: begin
        r_next.sys_rst = 1'b1;
        if (r_reg.hold != 4'h0) begin
          r_next.hold = r_reg.hold - 4'h1;
        end else if (ext_rst_n && !supply_low) begin
          // stay in reset while the pin or the supply still asks for it
          r_next.st      = RSC_RUN;
          r_next.sys_rst = 1'b0;
          r_next.pin_oe  = 1'b0;
        end
      end
      default: begin
        r_next = RSC_TOP_RST;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= RSC_TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sfr_rdata  = r_reg.rdata;
  assign sys_reset  = r_reg.sys_rst;
  assign rst_pin_oe = r_reg.pin_oe;
  assign mcd_enable = r_reg.mcd_en;
  assign vdm_select = r_reg.vdm_sel;
  assign flags_lo   = r_reg.flags[6:0];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_cmp_on;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && r_reg.cmp_en && cmp_below) |=> (sys_reset && r_reg.flags.cmp);
  endproperty
  a_cmp_on: assert property (p_cmp_on)
    else $error("enabled comparator did not reset");

  property p_cmp_off;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && !r_reg.cmp_en && cmp_below &&
     ((8'(cause) & RSC_OTHER_THAN_CMP) == 8'h00)) |=> !sys_reset;
  endproperty
  a_cmp_off: assert property (p_cmp_off)
    else $error("disabled comparator caused a reset");

  property p_sw_force;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && sfr.wr && sfr.addr == RSC_CAUSE_ADDR && sfr.wdata[RSC_BIT_SW])
      |=> (sys_reset && r_reg.flags.sw);
  endproperty
  a_sw_force: assert property (p_sw_force)
    else $error("software force did not reset");

  property p_wdt_flag;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && wdt_ovf) |=> (sys_reset && r_reg.flags.wdt);
  endproperty
  a_wdt_flag: assert property (p_wdt_flag)
    else $error("watchdog overflow not recorded");

  property p_flash_flag;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && flash_err) |=> (sys_reset && r_reg.flags.flash);
  endproperty
  a_flash_flag: assert property (p_flash_flag)
    else $error("flash fault not recorded");

  property p_pin_quiet;
    @(posedge mclk) disable iff (!arst_n)
    (sys_reset && !r_reg.flags.por) |-> !rst_pin_oe;
  endproperty
  a_pin_quiet: assert property (p_pin_quiet)
    else $error("internal reset drove the pin");

  property p_readback;
    @(posedge mclk) disable iff (!arst_n)
    rd_hit |=> (sfr_rdata == {1'b0, $past(flags_lo)});
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read-back wrong");

  property p_hold_len;
    @(posedge mclk) disable iff (!arst_n)
    $rose(sys_reset) |-> sys_reset [*8];
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("system reset too short");

  property p_mcd_flag;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && !r_reg.mcd_en && !r_reg.flags.lost_clock_detector) |=> !r_reg.flags.lost_clock_detector;
  endproperty
  a_mcd_flag: assert property (p_mcd_flag)
    else $error("lost clock flag without enabled detector");

  property p_supply_flag;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && supply_low) |=> (sys_reset && r_reg.flags.por && rst_pin_oe);
  endproperty
  a_supply_flag: assert property (p_supply_flag)
    else $error("supply reset not recorded");

  property p_pin_cause;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && !ext_rst_n) |=> (sys_reset && r_reg.flags.pin);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("pin reset not recorded");

  property p_mcd_cause;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && r_reg.mcd_en && mcd_timeout) |=> (sys_reset && r_reg.flags.lost_clock_detector);
  endproperty
  a_mcd_cause: assert property (p_mcd_cause)
    else $error("lost clock reset not recorded");

  property p_wr_enables;
    @(posedge mclk) disable iff (!arst_n)
    wr_hit |=> (mcd_enable == $past(sfr.wdata[RSC_BIT_MCD]) &&
                vdm_select == $past(sfr.wdata[RSC_BIT_VDM]));
  endproperty
  a_wr_enables: assert property (p_wr_enables)
    else $error("enable bits not taken from write");

  property p_cmp_write;
    @(posedge mclk) disable iff (!arst_n)
    (wr_hit && !(|cause)) |=> (r_reg.cmp_en == $past(sfr.wdata[RSC_BIT_CMP]));
  endproperty
  a_cmp_write: assert property (p_cmp_write)
    else $error("comparator enable not taken from write");

  property p_flags_keep;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && !(|cause)) |=> $stable(r_reg.flags);
  endproperty
  a_flags_keep: assert property (p_flags_keep)
    else $error("cause flags changed outside reset entry");

  property p_idle_quiet;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && !(|cause)) |=> !sys_reset;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("reset without an enabled request");

  property p_entry_flags;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_RUN && (|cause)) |=> (r_reg.flags == $past(cause));
  endproperty
  a_entry_flags: assert property (p_entry_flags)
    else $error("flags differ from causes at entry");

  property p_hold_extend;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == RSC_HOLD && (!ext_rst_n || supply_low)) |=> sys_reset;
  endproperty
  a_hold_extend: assert property (p_hold_extend)
    else $error("reset left while pin or supply still low");

  c_sw_reset:    cover property (@(posedge mclk) disable iff (!arst_n)
                                 (r_reg.st == RSC_RUN && cause.sw));
  c_cmp_reset:   cover property (@(posedge mclk) disable iff (!arst_n)
                                 (r_reg.st == RSC_RUN && cause.cmp));
  c_wdt_reset:   cover property (@(posedge mclk) disable iff (!arst_n)
                                 (r_reg.st == RSC_RUN && cause.wdt));
  c_flash_reset: cover property (@(posedge mclk) disable iff (!arst_n)
                                 (r_reg.st == RSC_RUN && cause.flash));
  c_pin_reset:   cover property (@(posedge mclk) disable iff (!arst_n)
                                 (r_reg.st == RSC_RUN && cause.pin));

endmodule

/* File: testbench/rsc_flash_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// flash controller stand-in: one request per fire cycle
// ----------------------------------------------------------------
module rsc_flash_model
  import rsc_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          fire,
  input  wire rsc_acc_kind_t kind,
  input  wire logic [1:0]    bank,
  input  wire logic [15:0]   addr,
  input  wire logic          secure,
  output rsc_flash_req_t     req
);
  logic [15:0] last_addr;

  // remember the address so idle cycles can show its inverse
  always @(posedge mclk) begin
    if (fire) begin
      last_addr <= addr;
    end
  end

  // idle bus never repeats the last request, so a stale match cannot pass
  always_comb begin
    if (fire) begin
      req = '{1'b1, kind, bank, addr, secure};
    end else begin
      req = '{1'b0, RSC_ACC_FETCH, 2'h3, ~last_addr, 1'b1};
    end
  end
endmodule

/* File: testbench/test_reset_source_control.sv */
`timescale 1ns/10ps
module test_reset_source_control;
  import rsc_pkg::*;
  localparam int  WDT_LIM = 4;
  localparam logic [7:0] RA = RSC_CAUSE_ADDR;
  logic           mclk, arst_n, cmp_below, mcd_timeout, vdm_enabled, vdm_high;
  logic           vdm_below, ext_rst_n, store_write_en, wdt_kick, wdt_off, fire;
  logic           secure, sys_reset, rst_pin_oe, mcd_enable, vdm_select, wdt_running;
  logic [1:0]     bank;
  logic [15:0]    addr;
  logic [7:0]     sfr_rdata, d;
  rsc_acc_kind_t  kind;
  rsc_sfr_req_t   sfr;
  rsc_flash_req_t flash_req;
  int             failures, n_tests, cyc;

  // ----------------------------------------------------------------
  // clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  rsc_reset_source_control #(.WDT_LIMIT(WDT_LIM), .REDUCED_MEM(1'b0)) i_rsc_reset_source_control (
    .mclk(mclk), .arst_n(arst_n), .sfr(sfr), .sfr_rdata(sfr_rdata), .cmp_below(cmp_below),
    .mcd_timeout(mcd_timeout), .vdm_enabled(vdm_enabled), .vdm_high(vdm_high),
    .vdm_below(vdm_below), .ext_rst_n(ext_rst_n), .flash_req(flash_req),
    .store_write_en(store_write_en), .wdt_kick(wdt_kick), .wdt_off(wdt_off),
    .sys_reset(sys_reset), .rst_pin_oe(rst_pin_oe), .mcd_enable(mcd_enable),
    .vdm_select(vdm_select), .wdt_running(wdt_running));

  rsc_flash_model i_rsc_flash_model (
    .mclk(mclk), .fire(fire), .kind(kind), .bank(bank), .addr(addr), .secure(secure),
    .req(flash_req));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // plain writes only, flags must never be written back as enables
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfr = '{1'b1, 1'b0, a, v};
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge mclk);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    v = sfr_rdata;
    sfr.rd = 1'b0;
  endtask

  // reset must stay away for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge mclk);
      check(sys_reset, 1'b0);
    end
  endtask

  // wait for exit from reset; watchdog is switched off unless dog is set
  task automatic settle(input bit dog);
    int i;
    i = 0;
    while (sys_reset !== 1'b0) begin
      if (i == 80) begin
        failures++;
        summarize();
      end
      @(negedge mclk);
      i++;
    end
    check(wdt_running, 1'b1); // watchdog up after reset
    if (!dog) begin
      wdt_off = 1'b1;
      @(negedge mclk);
      wdt_off = 1'b0;
    end
  endtask

  // a reset must arrive within lim cycles, then the flags are read back
  task automatic expect_rst(input int lim, input logic pin, input logic [7:0] flags);
    int i;
    i = 0;
    while (sys_reset !== 1'b1) begin
      if (i == lim) begin
        failures++;
        summarize();
      end
      @(negedge mclk);
      i++;
    end
    cyc = i;
    @(negedge mclk);
    check(rst_pin_oe, pin); // pin driven only for supply reset
    vdm_below = 1'b0;
    settle(1'b0);
    sfr_rd(RA, d);
    check(d, flags); // cause captured on entry
  endtask

  task automatic flash_case(input rsc_acc_kind_t k, input logic [1:0] b, input logic [15:0] a,
                            input logic s, input logic swe, input logic hi, input logic bad);
    @(negedge mclk);
    kind = k;
    bank = b;
    addr = a;
    secure = s;
    store_write_en = swe;
    vdm_high = hi;
    fire = 1'b1;
    @(negedge mclk);
    fire = 1'b0;
    if (bad) expect_rst(6, 1'b0, 8'h40); // flash fault flag
    else quiet(6);
    store_write_en = 1'b0;
    vdm_high = 1'b1;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    sfr = '0;
    {cmp_below, mcd_timeout, vdm_below, store_write_en, wdt_kick, wdt_off, fire} = 7'h00;
    {vdm_enabled, vdm_high, ext_rst_n, secure} = 4'he;
    kind = RSC_ACC_FETCH;
    bank = 2'h0;
    addr = 16'h0000;
    failures = 0;
    n_tests = 0;
    repeat (16) @(negedge mclk);
    check(sys_reset, 1'b1); // held in reset
    arst_n = 1'b1;
    settle(1'b1);
    sfr_rd(RA, d);
    check(d, 8'h02); // power-up flag
    // a serviced watchdog never fires, then an unserviced one does
    repeat (5) begin
      quiet(30); // serviced in time
      wdt_kick = 1'b1;
      @(negedge mclk);
      wdt_kick = 1'b0;
    end
    expect_rst(70, 1'b0, 8'h08); // overflow reset
    check(8'(cyc >= 12 * (WDT_LIM - 1) && cyc <= 12 * WDT_LIM + 4), 8'h01); // divide
    sfr_wr(RA, 8'h10); // forced reset
    expect_rst(3, 1'b0, 8'h10); // software flag set, pin untouched
    check(mcd_enable, 1'b0); // cleared by the plain write
    check(vdm_select, 1'b0); // cleared by the plain write
    cmp_below = 1'b1; // comparator settled before enabling
    quiet(10); // disabled comparator is ignored
    sfr_wr(RA, 8'h20); // enable comparator reset
    expect_rst(4, 1'b0, 8'h20); // comparator cause
    cmp_below = 1'b0;
    mcd_timeout = 1'b1;
    quiet(5); // detector disabled
    mcd_timeout = 1'b0;
    sfr_wr(RA, 8'h04);
    check(mcd_enable, 1'b1); // detector enable
    mcd_timeout = 1'b1;
    @(negedge mclk);
    mcd_timeout = 1'b0;
    expect_rst(4, 1'b0, 8'h04); // lost clock cause, comparator bit 0
    ext_rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    ext_rst_n = 1'b1;
    expect_rst(2, 1'b0, 8'h01); // pin cause
    sfr_wr(RA, 8'h80);
    sfr_rd(RA, d);
    check(d, 8'h01); // top bit reads 0 and is ignored
    sfr_rd(8'hee, d);
    check(d, 8'h00); // unmapped address reads 0
    sfr_wr(RA, 8'h02); // monitor already enabled
    check(vdm_select, 1'b1); // supply source selected
    // flash accesses: legal ones pass, each illegal one resets
    flash_case(RSC_ACC_DATA_WRITE, 2'h3, 16'hfc00, 1'b0, 1'b1, 1'b1, 1'b1);
    flash_case(RSC_ACC_DATA_WRITE, 2'h3, 16'hfbff, 1'b0, 1'b1, 1'b1, 1'b0);
    flash_case(RSC_ACC_DATA_WRITE, 2'h3, 16'hfc00, 1'b0, 1'b0, 1'b1, 1'b0);
    flash_case(RSC_ACC_ERASE, 2'h3, 16'hfc00, 1'b0, 1'b1, 1'b1, 1'b1);
    flash_case(RSC_ACC_CODE_READ, 2'h3, 16'hfc00, 1'b0, 1'b0, 1'b1, 1'b1);
    flash_case(RSC_ACC_CODE_READ, 2'h2, 16'hffff, 1'b0, 1'b0, 1'b1, 1'b0);
    flash_case(RSC_ACC_FETCH, 2'h3, 16'hfc00, 1'b0, 1'b0, 1'b1, 1'b1);
    flash_case(RSC_ACC_FETCH, 2'h3, 16'hfbff, 1'b0, 1'b0, 1'b1, 1'b0);
    flash_case(RSC_ACC_CODE_READ, 2'h0, 16'h0100, 1'b1, 1'b0, 1'b1, 1'b1);
    flash_case(RSC_ACC_CODE_READ, 2'h0, 16'h0100, 1'b0, 1'b0, 1'b0, 1'b1);
    vdm_below = 1'b1;
    expect_rst(4, 1'b1, 8'h02); // supply reset drives the pin
    summarize();
  end
endmodule
